//--- tas_pkg.sv
// Shared constants of the tariff accumulation selector and its accumulator cell
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Package
package tas_pkg;
   // Tariff type codes, two BCD digits as configured
   localparam logic [7:0] TAS_TT_NONE = 8'h00;
   localparam logic [7:0] TAS_TT_POWER = 8'h11;
   localparam logic [7:0] TAS_TT_FLOW = 8'h12;
   localparam logic [7:0] TAS_TT_DELTA = 8'h13;
   localparam logic [7:0] TAS_TT_INLET = 8'h14;
   localparam logic [7:0] TAS_TT_OUTLET = 8'h15;
   localparam logic [7:0] TAS_TT_TIME = 8'h19;
   localparam logic [7:0] TAS_TT_HCVOL = 8'h20;
   localparam logic [7:0] TAS_TT_PF = 8'h21;
   // Default widths
   localparam int TAS_ACC_W = 32;
   localparam int TAS_INC_W = 16;
   localparam int TAS_MEAS_W = 16;
   localparam int TAS_TOD_W = 11;
   // Values after reset
   localparam logic [2:0] TAS_SEL_RST = 3'h0;
   localparam logic [7:0] TAS_TT_RST = 8'h00;
endpackage

// ==========================================================
// Accumulator cell: adds the increment when enabled
module tas_accum
   import tas_pkg::*;
#(
   parameter int ACC_W = TAS_ACC_W,
   parameter int INC_W = TAS_INC_W
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Increment
   input wire logic add_en,
   input wire logic [INC_W-1:0] inc,
   // Sum
   output logic [ACC_W-1:0] acc_r
);
   logic [ACC_W-1:0] acc_nxt;

   always_comb begin
      acc_nxt = acc_r;
      if (add_en) begin
         acc_nxt = acc_r + {{(ACC_W-INC_W){1'b0}}, inc};
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         acc_r <= '0;
      end else begin
         acc_r <= acc_nxt;
      end
   end
endmodule

`default_nettype wire

//--- tas_selector.sv
// Tariff selection and accumulation for a heat or cooling meter
// Function
// - Main register always takes every increment
// - Limits evaluated afresh every integration step
// - Three auxiliary accumulators; volume in type 20
// - All limits read under one tariff type
// - Fourth limit zero disables fourth accumulator
// - Type 00 disables all tariff accumulation
// - Type 11 compares power against limits
// - Type 12 flow, type 13 temperature difference
// - Type 14 inlet, type 15 outlet temperature
// - Type 19 limits are start times of day
// - Type 20 splits volume by inlet/outlet
// - Type 21 power to second, flow third
// - Power at or below second: main only
// - Power above second up to third: second
// - Power above third up to fourth: third
// - Power above fourth: fourth accumulator
// - Flow bands select like power bands
// - Temperature difference bands are inverted
// - Fourth time band wraps to second start
// - Heat volume needs inlet at threshold
`timescale 1ns/1ps
`default_nettype none

module tas_selector
   import tas_pkg::*;
#(
   parameter int ACC_W = TAS_ACC_W,
   parameter int INC_W = TAS_INC_W,
   parameter int MEAS_W = TAS_MEAS_W,
   parameter int TOD_W = TAS_TOD_W
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Integration step from the measurement datapath
   input wire logic step_valid,
   input wire logic [INC_W-1:0] energy_inc,
   input wire logic [INC_W-1:0] volume_inc,
   // Measurements
   input wire logic [MEAS_W-1:0] power,
   input wire logic [MEAS_W-1:0] flow,
   input wire logic signed [MEAS_W-1:0] inlet_temperature,
   input wire logic signed [MEAS_W-1:0] outlet_temperature,
   input wire logic [TOD_W-1:0] time_of_day,
   // Configuration
   input wire logic [7:0] tariff_type_select,
   input wire logic [MEAS_W-1:0] tariff_limit_second,
   input wire logic [MEAS_W-1:0] tariff_limit_third,
   input wire logic [MEAS_W-1:0] tariff_limit_fourth,
   input wire logic signed [MEAS_W-1:0] heat_cool_threshold,
   // Registers
   output logic [ACC_W-1:0] main_energy_register,
   output logic [ACC_W-1:0] total_volume_register,
   output logic [ACC_W-1:0] tariff_accum_second,
   output logic [ACC_W-1:0] tariff_accum_third,
   output logic [ACC_W-1:0] tariff_accum_fourth,
   // Status of the last step
   output logic [2:0] tariff_sel_r,
   output logic tariff_code_bad_r
);
   localparam int CW = MEAS_W + 1;

   // ==========================================================
   // Helpers
   function automatic logic signed [CW-1:0] ext_u(input logic [MEAS_W-1:0] v);
      ext_u = signed'({1'b0, v});
   endfunction

   function automatic logic signed [CW-1:0] ext_s(input logic [MEAS_W-1:0] v);
      ext_s = signed'({v[MEAS_W-1], v});
   endfunction

   // Rising bands: above second limit and up to the next one
   function automatic logic [2:0] band_up(input logic signed [CW-1:0] v,
                                          input logic signed [CW-1:0] l2,
                                          input logic signed [CW-1:0] l3,
                                          input logic signed [CW-1:0] l4,
                                          input logic l4_on);
      if (v <= l2) begin
         band_up = 3'h0;
      end else if (v <= l3) begin
         band_up = 3'h1;
      end else if (!l4_on || v <= l4) begin
         band_up = 3'h2;
      end else begin
         band_up = 3'h4;
      end
   endfunction

   // Falling bands: below second limit and at least the next one
   function automatic logic [2:0] band_dn(input logic signed [CW-1:0] v,
                                          input logic signed [CW-1:0] l2,
                                          input logic signed [CW-1:0] l3,
                                          input logic signed [CW-1:0] l4,
                                          input logic l4_on);
      if (v >= l2) begin
         band_dn = 3'h0;
      end else if (v >= l3) begin
         band_dn = 3'h1;
      end else if (!l4_on || v >= l4) begin
         band_dn = 3'h2;
      end else begin
         band_dn = 3'h4;
      end
   endfunction

   // Time window from start inclusive to end exclusive, wrapping at midnight
   function automatic logic in_window(input logic [TOD_W-1:0] t,
                                      input logic [TOD_W-1:0] a,
                                      input logic [TOD_W-1:0] b);
      if (a <= b) begin
         in_window = (t >= a) && (t < b);
      end else begin
         in_window = (t >= a) || (t < b);
      end
   endfunction

   // ==========================================================
   // Operand preparation
   logic l4_on;
   logic signed [CW-1:0] lim2_u, lim3_u, lim4_u;
   logic signed [CW-1:0] lim2_s, lim3_s, lim4_s;
   logic signed [CW-1:0] delta_t;
   logic signed [CW-1:0] t_in, t_out, t_hc;
   logic [TOD_W-1:0] tod2, tod3, tod4;

   assign l4_on = (tariff_limit_fourth != '0);
   assign lim2_u = ext_u(tariff_limit_second);
   assign lim3_u = ext_u(tariff_limit_third);
   assign lim4_u = ext_u(tariff_limit_fourth);
   assign lim2_s = ext_s(tariff_limit_second);
   assign lim3_s = ext_s(tariff_limit_third);
   assign lim4_s = ext_s(tariff_limit_fourth);
   assign t_in = ext_s(inlet_temperature);
   assign t_out = ext_s(outlet_temperature);
   assign t_hc = ext_s(heat_cool_threshold);
   assign delta_t = t_in - t_out;
   assign tod2 = tariff_limit_second[TOD_W-1:0];
   assign tod3 = tariff_limit_third[TOD_W-1:0];
   assign tod4 = tariff_limit_fourth[TOD_W-1:0];

   // ==========================================================
   // Tariff decision, evaluated for every step
   logic [2:0] sel_c;
   logic code_bad_c;
   logic aux_is_volume;

   always_comb begin
      sel_c = 3'h0;
      code_bad_c = 1'b0;
      unique case (tariff_type_select)
         TAS_TT_NONE: begin
            sel_c = 3'h0;
         end
         TAS_TT_POWER: begin
            sel_c = band_up(ext_u(power), lim2_u, lim3_u, lim4_u, l4_on);
         end
         TAS_TT_FLOW: begin
            sel_c = band_up(ext_u(flow), lim2_u, lim3_u, lim4_u, l4_on);
         end
         TAS_TT_DELTA: begin
            sel_c = band_dn(delta_t, lim2_s, lim3_s, lim4_s, l4_on);
         end
         TAS_TT_INLET: begin
            sel_c = band_up(t_in, lim2_s, lim3_s, lim4_s, l4_on);
         end
         TAS_TT_OUTLET: begin
            sel_c = band_up(t_out, lim2_s, lim3_s, lim4_s, l4_on);
         end
         TAS_TT_TIME: begin
            if (in_window(time_of_day, tod2, tod3)) begin
               sel_c = 3'h1;
            end else if (l4_on) begin
               if (in_window(time_of_day, tod3, tod4)) begin
                  sel_c = 3'h2;
               end else if (in_window(time_of_day, tod4, tod2)) begin
                  sel_c = 3'h4;
               end
            end else if (in_window(time_of_day, tod3, tod2)) begin
               sel_c = 3'h2;
            end
         end
         TAS_TT_HCVOL: begin
            if (t_in > t_out && t_in >= t_hc) begin
               sel_c = 3'h1;
            end else if (t_out > t_in && t_in <= t_hc) begin
               sel_c = 3'h2;
            end
         end
         TAS_TT_PF: begin
            sel_c[0] = ext_u(power) > lim2_u;
            sel_c[1] = ext_u(flow) > lim3_u;
         end
         default: begin
            code_bad_c = 1'b1; // Unknown code acts as no tariff
         end
      endcase
   end

   assign aux_is_volume = (tariff_type_select == TAS_TT_HCVOL);

   // ==========================================================
   // Step status registers
   logic [2:0] tariff_sel_nxt;
   logic tariff_code_bad_nxt;

   always_comb begin
      tariff_sel_nxt = tariff_sel_r;
      tariff_code_bad_nxt = tariff_code_bad_r;
      if (step_valid) begin
         tariff_sel_nxt = sel_c;
         tariff_code_bad_nxt = code_bad_c;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tariff_sel_r <= TAS_SEL_RST;
         tariff_code_bad_r <= 1'b0;
      end else begin
         tariff_sel_r <= tariff_sel_nxt;
         tariff_code_bad_r <= tariff_code_bad_nxt;
      end
   end

   // ==========================================================
   // Accumulators
   logic [INC_W-1:0] aux_inc;

   assign aux_inc = aux_is_volume ? volume_inc : energy_inc;

   tas_accum #(.ACC_W(ACC_W), .INC_W(INC_W)) u_main (
      .clock(clock),
      .rst_n(rst_n),
      .add_en(step_valid),
      .inc(energy_inc),
      .acc_r(main_energy_register)
   );

   tas_accum #(.ACC_W(ACC_W), .INC_W(INC_W)) u_volume (
      .clock(clock),
      .rst_n(rst_n),
      .add_en(step_valid),
      .inc(volume_inc),
      .acc_r(total_volume_register)
   );

   tas_accum #(.ACC_W(ACC_W), .INC_W(INC_W)) u_second (
      .clock(clock),
      .rst_n(rst_n),
      .add_en(step_valid && sel_c[0]),
      .inc(aux_inc),
      .acc_r(tariff_accum_second)
   );

   tas_accum #(.ACC_W(ACC_W), .INC_W(INC_W)) u_third (
      .clock(clock),
      .rst_n(rst_n),
      .add_en(step_valid && sel_c[1]),
      .inc(aux_inc),
      .acc_r(tariff_accum_third)
   );

   tas_accum #(.ACC_W(ACC_W), .INC_W(INC_W)) u_fourth (
      .clock(clock),
      .rst_n(rst_n),
      .add_en(step_valid && sel_c[2]),
      .inc(aux_inc),
      .acc_r(tariff_accum_fourth)
   );

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   AST_MAIN_ALWAYS: assert property (
      step_valid |=> main_energy_register ==
         $past(main_energy_register) + {{(ACC_W-INC_W){1'b0}}, $past(energy_inc)})
      else $error("main register missed an increment");

   AST_NONE_HOLDS: assert property (
      step_valid && tariff_type_select == TAS_TT_NONE |=>
         tariff_sel_r == 3'h0 && $stable(tariff_accum_second) &&
         $stable(tariff_accum_third) && $stable(tariff_accum_fourth))
      else $error("tariff accumulated with no tariff type");

   AST_POWER_LOW: assert property (
      step_valid && tariff_type_select == TAS_TT_POWER &&
         power <= tariff_limit_second |=> tariff_sel_r == 3'h0)
      else $error("power at or below second limit selected a tariff");

   AST_POWER_B2: assert property (
      step_valid && tariff_type_select == TAS_TT_POWER &&
         power > tariff_limit_second && power <= tariff_limit_third
         |=> tariff_sel_r == 3'h1 && tariff_accum_second ==
         $past(tariff_accum_second) + {{(ACC_W-INC_W){1'b0}}, $past(energy_inc)})
      else $error("power band two not accumulated");

   AST_POWER_B3: assert property (
      step_valid && tariff_type_select == TAS_TT_POWER && power > tariff_limit_third &&
         power > tariff_limit_second &&
         (tariff_limit_fourth == '0 || power <= tariff_limit_fourth) |=> tariff_sel_r == 3'h2)
      else $error("power band three not selected");

   AST_POWER_B4: assert property (
      step_valid && tariff_type_select == TAS_TT_POWER && tariff_limit_fourth != '0 &&
         power > tariff_limit_fourth && power > tariff_limit_third &&
         power > tariff_limit_second |=> tariff_sel_r == 3'h4)
      else $error("power band four not selected");

   AST_FOURTH_OFF: assert property (
      step_valid && tariff_limit_fourth == '0 |=> !tariff_sel_r[2] && $stable(tariff_accum_fourth))
      else $error("fourth accumulator used while disabled");

   AST_ONE_AUX: assert property (
      step_valid && tariff_type_select != TAS_TT_PF |=> $onehot0(tariff_sel_r))
      else $error("more than one auxiliary accumulator selected");

   AST_HCVOL_VOLUME: assert property (
      step_valid && tariff_type_select == TAS_TT_HCVOL &&
         inlet_temperature > outlet_temperature &&
         inlet_temperature >= heat_cool_threshold |=>
         tariff_accum_second == $past(tariff_accum_second) +
         {{(ACC_W-INC_W){1'b0}}, $past(volume_inc)} && !tariff_sel_r[2])
      else $error("heat volume not added to second accumulator");

   AST_HCVOL_COLD: assert property (
      step_valid && tariff_type_select == TAS_TT_HCVOL &&
         inlet_temperature < heat_cool_threshold |=> !tariff_sel_r[0])
      else $error("heat volume below threshold");

   AST_PF_SPLIT: assert property (
      step_valid && tariff_type_select == TAS_TT_PF |=>
         tariff_sel_r[0] == ($past(power) > $past(tariff_limit_second)) &&
         tariff_sel_r[1] == ($past(flow) > $past(tariff_limit_third)))
      else $error("combined tariff selection wrong");

   AST_FLOW_LOW: assert property (
      step_valid && tariff_type_select == TAS_TT_FLOW &&
         flow <= tariff_limit_second |=> tariff_sel_r == 3'h0)
      else $error("flow at or below second limit selected a tariff");

   COV_POWER_B4: cover property (step_valid && tariff_type_select == TAS_TT_POWER ##1
      tariff_sel_r == 3'h4);
   COV_TIME_B3: cover property (step_valid && tariff_type_select == TAS_TT_TIME ##1
      tariff_sel_r == 3'h2);
   COV_HCVOL_COOL: cover property (step_valid && tariff_type_select == TAS_TT_HCVOL ##1
      tariff_sel_r == 3'h2);
   COV_PF_BOTH: cover property (step_valid && tariff_type_select == TAS_TT_PF ##1
      tariff_sel_r == 3'h3);
endmodule

`default_nettype wire

//--- tas_datapath_model.sv
// Behavioural model of the measurement and integration datapath
`timescale 1ns/1ps
`default_nettype none

module tas_datapath_model
   import tas_pkg::*;
(
   // Clock
   input wire logic clock,
   // Integration step
   output logic step_valid,
   output logic [TAS_INC_W-1:0] energy_inc,
   output logic [TAS_INC_W-1:0] volume_inc,
   // Measurements
   output logic [TAS_MEAS_W-1:0] power,
   output logic [TAS_MEAS_W-1:0] flow,
   output logic signed [TAS_MEAS_W-1:0] inlet_temperature,
   output logic signed [TAS_MEAS_W-1:0] outlet_temperature,
   output logic [TAS_TOD_W-1:0] time_of_day
);
   // ==========================================================
   // Idle state
   initial begin
      step_valid = 1'b0;
      energy_inc = 16'h0000;
      volume_inc = 16'h0000;
      power = 16'h0000;
      flow = 16'h0000;
      inlet_temperature = 16'sh0000;
      outlet_temperature = 16'sh0000;
      time_of_day = 11'h000;
   end

   // ==========================================================
   // Step issue: gap plus one idle cycles, then n steps back to back
   task automatic issue(input int gap, input int n, input logic [15:0] e, input logic [15:0] v,
                        input logic [15:0] p, input logic [15:0] f, input logic [15:0] tin,
                        input logic [15:0] tout, input logic [10:0] tod);
      repeat (gap) @(posedge clock);
      @(posedge clock);
      #1;
      step_valid = 1'b1;
      energy_inc = e;
      volume_inc = v;
      power = p;
      flow = f;
      inlet_temperature = tin;
      outlet_temperature = tout;
      time_of_day = tod;
      repeat (n) @(posedge clock);
      #1;
      step_valid = 1'b0;
      // Released lines no longer show the step's values
      energy_inc = ~e;
      volume_inc = ~v;
      power = ~p;
      flow = ~f;
      inlet_temperature = ~tin;
      outlet_temperature = ~tout;
      time_of_day = ~tod;
   endtask
endmodule

`default_nettype wire

//--- tas_selector_test.sv
// Self-checking testbench of the tariff accumulation selector
`timescale 1ns/1ps
`default_nettype none

module tas_selector_test
   import tas_pkg::*;
;
   // ==========================================================
   // Signals
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic step_valid;
   logic [15:0] energy_inc, volume_inc, power, flow;
   logic signed [15:0] inlet_temperature, outlet_temperature, heat_cool_threshold;
   logic [10:0] time_of_day;
   logic [7:0] tariff_type_select;
   logic [15:0] tariff_limit_second, tariff_limit_third, tariff_limit_fourth;
   logic [31:0] main_energy_register, total_volume_register;
   logic [31:0] tariff_accum_second, tariff_accum_third, tariff_accum_fourth;
   logic [2:0] tariff_sel_r;
   logic tariff_code_bad_r;
   logic [31:0] exp_main, exp_vol, exp_a2, exp_a3, exp_a4;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   int k = 0;

   always #12.5 clock = ~clock;

   // ==========================================================
   // Instances
   tas_datapath_model dp (.clock(clock), .step_valid(step_valid), .energy_inc(energy_inc),
      .volume_inc(volume_inc), .power(power), .flow(flow),
      .inlet_temperature(inlet_temperature), .outlet_temperature(outlet_temperature),
      .time_of_day(time_of_day));

   tas_selector dut (.clock(clock), .rst_n(rst_n), .step_valid(step_valid),
      .energy_inc(energy_inc), .volume_inc(volume_inc), .power(power), .flow(flow),
      .inlet_temperature(inlet_temperature), .outlet_temperature(outlet_temperature),
      .time_of_day(time_of_day), .tariff_type_select(tariff_type_select),
      .tariff_limit_second(tariff_limit_second), .tariff_limit_third(tariff_limit_third),
      .tariff_limit_fourth(tariff_limit_fourth), .heat_cool_threshold(heat_cool_threshold),
      .main_energy_register(main_energy_register), .total_volume_register(total_volume_register),
      .tariff_accum_second(tariff_accum_second), .tariff_accum_third(tariff_accum_third),
      .tariff_accum_fourth(tariff_accum_fourth), .tariff_sel_r(tariff_sel_r),
      .tariff_code_bad_r(tariff_code_bad_r));

   // ==========================================================
   // Reporting
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         close_out();
      end
   end

   // ==========================================================
   // Access tasks
   task automatic clr();
      exp_main = 32'h0;
      exp_vol = 32'h0;
      exp_a2 = 32'h0;
      exp_a3 = 32'h0;
      exp_a4 = 32'h0;
   endtask

   task automatic check_all(input logic [2:0] sel, input logic bad);
      chk("main", main_energy_register, exp_main);
      chk("volume", total_volume_register, exp_vol);
      chk("second", tariff_accum_second, exp_a2);
      chk("third", tariff_accum_third, exp_a3);
      chk("fourth", tariff_accum_fourth, exp_a4);
      chk("selection", {29'h0, tariff_sel_r}, {29'h0, sel});
      chk("bad code", {31'h0, tariff_code_bad_r}, {31'h0, bad});
   endtask

   task automatic cfg(input logic [7:0] c, input int l2, input int l3, input int l4, input int t);
      @(posedge clock);
      #1;
      tariff_type_select = c;
      tariff_limit_second = 16'(l2);
      tariff_limit_third = 16'(l3);
      tariff_limit_fourth = 16'(l4);
      heat_cool_threshold = 16'(t);
   endtask

   task automatic stpn(input int n, input int p, input int f, input int tin, input int tout,
                       input int tod, input int sel);
      logic [15:0] e;
      logic [15:0] v;
      logic [31:0] a;
      logic bad;
      e = 16'h0010 + 16'(k);
      v = 16'h0200 + 16'(k);
      a = 32'(n) * ((tariff_type_select == TAS_TT_HCVOL) ? {16'h0, v} : {16'h0, e});
      bad = !(tariff_type_select inside {TAS_TT_NONE, TAS_TT_POWER, TAS_TT_FLOW, TAS_TT_DELTA,
         TAS_TT_INLET, TAS_TT_OUTLET, TAS_TT_TIME, TAS_TT_HCVOL, TAS_TT_PF});
      k++;
      dp.issue(k % 3, n, e, v, 16'(p), 16'(f), 16'(tin), 16'(tout), 11'(tod));
      exp_main += 32'(n) * {16'h0, e};
      exp_vol += 32'(n) * {16'h0, v};
      exp_a2 += sel[0] ? a : 32'h0;
      exp_a3 += sel[1] ? a : 32'h0;
      exp_a4 += sel[2] ? a : 32'h0;
      check_all(3'(sel), bad);
   endtask

   task automatic stp(input int p, input int f, input int tin, input int tout, input int tod,
                      input int sel);
      stpn(1, p, f, tin, tout, tod, sel);
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      tariff_type_select = TAS_TT_NONE;
      tariff_limit_second = 16'h0000;
      tariff_limit_third = 16'h0000;
      tariff_limit_fourth = 16'h0000;
      heat_cool_threshold = 16'sh0000;
      clr();
      repeat (4) @(posedge clock);
      #1;
      rst_n = 1'b1;
      check_all(3'h0, 1'b0);
      cfg(TAS_TT_POWER, 100, 200, 300, 0);
      stp(100, 0, 0, 0, 0, 0);
      stp(101, 999, 0, 0, 0, 1);
      stp(200, 0, 0, 0, 0, 1);
      stp(201, 0, 0, 0, 0, 2);
      stp(300, 0, 0, 0, 0, 2);
      stp(301, 0, 0, 0, 0, 4);
      stpn(3, 65535, 0, 0, 0, 0, 4);
      cfg(TAS_TT_POWER, 100, 200, 0, 0);
      stp(301, 0, 0, 0, 0, 2);
      stp(150, 0, 0, 0, 0, 1);
      $display("test power finished");
      cfg(TAS_TT_FLOW, 100, 200, 300, 0);
      stp(999, 100, 0, 0, 0, 0);
      stp(0, 150, 0, 0, 0, 1);
      stp(0, 250, 0, 0, 0, 2);
      stp(0, 301, 0, 0, 0, 4);
      cfg(TAS_TT_DELTA, 30, 20, 10, 0);
      stp(0, 0, 60, 30, 0, 0);
      stp(0, 0, 59, 30, 0, 1);
      stp(0, 0, 50, 30, 0, 1);
      stp(0, 0, 49, 30, 0, 2);
      stp(0, 0, 40, 30, 0, 2);
      stp(0, 0, 39, 30, 0, 4);
      stp(0, 0, 20, 25, 0, 4);
      $display("test flow and difference finished");
      cfg(TAS_TT_INLET, 40, 60, 80, 0);
      stp(0, 0, 40, 0, 0, 0);
      stp(0, 0, 41, 0, 0, 1);
      stp(0, 0, 61, 0, 0, 2);
      stp(0, 0, 81, 0, 0, 4);
      cfg(TAS_TT_OUTLET, 40, 60, 80, 0);
      stp(0, 0, 99, 40, 0, 0);
      stp(0, 0, 0, 61, 0, 2);
      stp(0, 0, 0, 81, 0, 4);
      $display("test temperature finished");
      cfg(TAS_TT_TIME, 480, 960, 1380, 0);
      stp(0, 0, 0, 0, 479, 4);
      stp(0, 0, 0, 0, 480, 1);
      stp(0, 0, 0, 0, 959, 1);
      stp(0, 0, 0, 0, 960, 2);
      stp(0, 0, 0, 0, 1380, 4);
      stp(0, 0, 0, 0, 0, 4);
      cfg(TAS_TT_TIME, 480, 960, 0, 0);
      stp(0, 0, 0, 0, 1400, 2);
      stp(0, 0, 0, 0, 100, 2);
      stp(0, 0, 0, 0, 500, 1);
      $display("test time finished");
      cfg(TAS_TT_HCVOL, 5, 5, 5, 30);
      stp(0, 0, 30, 20, 0, 1);
      stp(0, 0, 29, 20, 0, 0);
      stp(0, 0, 30, 40, 0, 2);
      stp(0, 0, 31, 40, 0, 0);
      stp(0, 0, 30, 30, 0, 0);
      cfg(TAS_TT_PF, 100, 200, 0, 0);
      stp(101, 201, 0, 0, 0, 3);
      stp(100, 200, 0, 0, 0, 0);
      stp(150, 10, 0, 0, 0, 1);
      stp(0, 300, 0, 0, 0, 2);
      cfg(TAS_TT_NONE, 100, 200, 300, 0);
      stp(999, 999, 99, 0, 1000, 0);
      cfg(8'h16, 100, 200, 300, 0);
      stp(999, 999, 99, 0, 1000, 0);
      $display("test volume, combined and none finished");
      @(posedge clock);
      #1;
      rst_n = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      rst_n = 1'b1;
      clr();
      check_all(3'h0, 1'b0);
      $display("test second reset finished");
      close_out();
   end
endmodule

`default_nettype wire
